// File: verilog/adc_scan_readout_sequencer.sv
// Purpose: two-wire bus slave, scan sequencer and result readout
// Assumes: SCL/SDA sampled on clk_sys; converter core is start/done
// Notes: clock stretch and ack driven as open-drain enables
`timescale 1ns/100ps
module adc_scan_readout_sequencer
    import adc_seq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl_in,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_oe,
    output logic conv_start,
    output mux_sel_t conv_mux,
    output logic conv_ext_clk,
    input wire logic conv_done,
    input wire logic [RESULT_BITS-1:0] conv_result,
    output logic busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b011,
        ST_WRX = 3'b010,
        ST_WACK = 3'b110,
        ST_CONV = 3'b111,
        ST_TX = 3'b101,
        ST_MACK = 3'b100
    } bus_state_t;

    bus_state_t state;
    conv_cfg_t cfg;
    logic clk_src_ext;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rd_mode;
    logic [7:0] tx_byte;
    logic tx_hi;
    logic sda_drive;
    logic stretch;
    logic [3:0] conv_left;
    logic [3:0] conv_idx;
    logic conv_busy;
    logic [1:0] ext_delay;
    logic ext_pending;
    result_t mem [0:MEM_DEPTH-1];
    logic mem_wr;
    logic mem_rd;
    logic [3:0] stored;
    logic [15:0] stretch_cnt;
    logic stretch_over;

    // Pin synchronisers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    wire scl = scl_sync[1];
    wire sda = sda_sync[1];
    wire scl_rise = scl && !scl_d;
    wire scl_fall = !scl && scl_d;
    wire start_cond = scl && scl_d && sda_d && !sda;
    wire stop_cond = scl && scl_d && !sda_d && sda;

    wire addr_hit = (shreg[7:1] == DEV_ADDR);
    wire is_setup = shreg[CMD_KIND_BIT];
    // Reserved code runs once so the stretch always ends
    wire [1:0] seq_eff = (cfg.seq == SEQ_RSVD) ? SEQ_ONCE : cfg.seq;

    // Scan plan: number of conversions and which input each uses
    wire [3:0] plan_len = (seq_eff == SEQ_UP) ? {3'h0, cfg.pick} + 4'h1 :
        (seq_eff == SEQ_EIGHT) ? 4'(REPEAT_COUNT) : 4'h1;
    wire cur_pick = (seq_eff == SEQ_UP) ? conv_idx[0] : cfg.pick;

    // Mux selection: single-ended against ground or differential pair
    assign conv_mux.pos_b = cur_pick;
    assign conv_mux.neg_gnd = cfg.single;
    assign conv_mux.neg_a = !cfg.single && cur_pick;
    assign conv_mux.neg_b = !cfg.single && !cur_pick;
    assign conv_ext_clk = clk_src_ext;
    assign busy = conv_busy;

    // Open-drain outputs: enable means pulling low
    assign scl_oe = stretch;
    assign sda_oe = sda_drive;

    // Transmit byte: internal mode six ones, external four ones
    wire [RESULT_BITS-1:0] rd_word = mem[mem_rd].data;
    wire [7:0] hi_int = {{INT_LEAD_ONES{1'b1}}, rd_word[9:8]};
    wire [7:0] hi_ext = {{EXT_LEAD_ONES{1'b1}}, rd_word[9:6]};
    wire [7:0] lo_int = rd_word[7:0];
    wire [7:0] lo_ext = {rd_word[5:0], 2'h0};
    wire [7:0] next_tx = tx_hi ? (clk_src_ext ? hi_ext : hi_int) :
        (clk_src_ext ? lo_ext : lo_int);
    // External bytes go out live: data bits trail the conversion as it lands
    wire [7:0] ext_cur = tx_hi ? lo_ext : hi_ext;
    wire [7:0] tx_src = clk_src_ext ? ext_cur : tx_byte;

    // Result buffer between converter core and result memory
    logic res_valid;
    logic res_ready;
    logic [RESULT_BITS-1:0] res_data;
    result_skid #(.WIDTH(RESULT_BITS)) u_skid (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(conv_done),
        .in_ready(),
        .in_data(conv_result),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );
    assign res_ready = 1'b1;

    assign stretch_over = (stretch_cnt >= 16'(STRETCH_CYCLES));

    // Bus state machine
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rd_mode <= 1'b0;
            sda_drive <= 1'b0;
            cfg <= {SEQ_RESET, PICK_RESET, STYLE_RESET};
            clk_src_ext <= CLKSRC_RESET;
            tx_byte <= 8'hFF;
            tx_hi <= 1'b1;
            stretch <= 1'b0;
        end else if (start_cond) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_drive <= 1'b0;
            stretch <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            sda_drive <= 1'b0;
            stretch <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    sda_drive <= 1'b0;
                end
                ST_ADDR, ST_WRX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_WRX) begin
                            sda_drive <= 1'b1;
                            state <= ST_WACK;
                            if (!is_setup) begin
                                cfg.seq <= shreg[SEQ_HI_BIT:SEQ_LO_BIT];
                                cfg.pick <= shreg[PICK_BIT];
                                cfg.single <= shreg[STYLE_BIT];
                            end else begin
                                clk_src_ext <= shreg[SETUP_CLK_BIT];
                                if (!shreg[SETUP_RST_BIT]) begin
                                    cfg <= {SEQ_RESET, PICK_RESET, STYLE_RESET};
                                end
                            end
                        end else if (addr_hit) begin
                            sda_drive <= 1'b1;
                            rd_mode <= shreg[0];
                            state <= ST_AACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        sda_drive <= 1'b0;
                        tx_hi <= 1'b1;
                        if (!rd_mode) begin
                            state <= ST_WRX;
                        end else if (!clk_src_ext) begin
                            stretch <= 1'b1;
                            state <= ST_CONV;
                        end else begin
                            tx_byte <= 8'hFF;
                            tx_hi <= 1'b0;
                            state <= ST_TX;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        sda_drive <= 1'b0;
                        state <= ST_WRX;
                    end
                end
                ST_CONV: begin
                    // Release only once every result is stored
                    if (!conv_busy && stored != 4'h0 && !ext_pending) begin
                        stretch <= 1'b0;
                        tx_byte <= next_tx;
                        sda_drive <= !next_tx[7];
                        tx_hi <= 1'b0;
                        state <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            sda_drive <= 1'b0;
                            state <= ST_MACK;
                        end else begin
                            sda_drive <= !tx_src[6 - bit_cnt[2:0]];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise && sda) begin
                        state <= ST_IDLE;
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        tx_byte <= next_tx;
                        sda_drive <= !next_tx[7];
                        tx_hi <= !tx_hi;
                        state <= ST_TX;
                    end
                end
            endcase
        end
    end

    // Conversion scheduler
    wire addr_read_ack = (state == ST_AACK) && scl_fall && rd_mode;
    // Restart only after the low byte is acked, so the word on the wire stays whole
    wire ext_restart = clk_src_ext && (state == ST_MACK) && scl_fall && tx_hi;
    assign mem_wr = res_valid;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            conv_busy <= 1'b0;
            conv_left <= 4'h0;
            conv_idx <= 4'h0;
            conv_start <= 1'b0;
            ext_delay <= 2'h0;
            ext_pending <= 1'b0;
            stored <= 4'h0;
            mem_rd <= 1'b0;
            stretch_cnt <= 16'h0000;
        end else begin
            conv_start <= 1'b0;
            if (addr_read_ack) begin
                // Fresh set per read access; old results discarded
                stored <= 4'h0;
                mem_rd <= 1'b0;
                conv_idx <= 4'h0;
                conv_left <= plan_len;
                stretch_cnt <= 16'h0000;
                if (!clk_src_ext) begin
                    conv_busy <= 1'b1;
                    conv_start <= 1'b1;
                end else begin
                    ext_pending <= 1'b1;
                    ext_delay <= 2'(EXT_START_DELAY);
                end
            end else if (ext_pending) begin
                if (scl_rise) begin
                    if (ext_delay == 2'h1) begin
                        ext_pending <= 1'b0;
                        conv_busy <= 1'b1;
                        conv_start <= 1'b1;
                    end
                    ext_delay <= ext_delay - 2'h1;
                end
            end else if (ext_restart && !conv_busy) begin
                // External mode keeps converting until the master nacks
                conv_busy <= 1'b1;
                conv_start <= 1'b1;
                stored <= 4'h0;
                mem_rd <= 1'b0;
                if (seq_eff == SEQ_UP && conv_idx < {3'h0, cfg.pick}) begin
                    conv_idx <= conv_idx + 4'h1;
                end else begin
                    conv_idx <= 4'h0;
                end
            end else if (mem_wr) begin
                stored <= stored + 4'h1;
                if (!clk_src_ext && conv_left > 4'h1) begin
                    conv_left <= conv_left - 4'h1;
                    conv_idx <= conv_idx + 4'h1;
                    conv_start <= 1'b1;
                end else begin
                    conv_busy <= 1'b0;
                end
            end else if (state == ST_MACK && scl_fall && !tx_hi && !clk_src_ext) begin
                // Wraps to the first stored result
                mem_rd <= (stored > 4'h1) ? ~mem_rd : 1'b0;
            end
            if (conv_busy && !stretch_over) begin
                stretch_cnt <= stretch_cnt + 16'h0001;
            end
        end
    end

    // Result memory of two entries, newest kept in order
    always_ff @(posedge clk_sys) begin
        if (mem_wr) begin
            mem[stored[0]].data <= res_data;
        end
    end
endmodule

// File: verilog/adc_seq_pkg.sv
// Purpose: shared constants and types for the converter scan sequencer
// Assumes: system clock 20 MHz, two-wire bus pins sampled on that clock
// Notes: conversion engine is abstracted as a start/done handshake
package adc_seq_pkg;
    localparam int CLK_HZ = 20000000;
    localparam logic [6:0] DEV_ADDR = 7'h36;
    localparam int CMD_KIND_BIT = 7;
    localparam int SEQ_HI_BIT = 6;
    localparam int SEQ_LO_BIT = 5;
    localparam int PICK_BIT = 1;
    localparam int STYLE_BIT = 0;
    localparam int SETUP_CLK_BIT = 3;
    localparam int SETUP_RST_BIT = 1;
    localparam logic [1:0] SEQ_RESET = 2'h0;
    localparam logic PICK_RESET = 1'b0;
    localparam logic STYLE_RESET = 1'b1;
    localparam logic CLKSRC_RESET = 1'b0;
    localparam logic [1:0] SEQ_UP = 2'h0;
    localparam logic [1:0] SEQ_EIGHT = 2'h1;
    localparam logic [1:0] SEQ_RSVD = 2'h2;
    localparam logic [1:0] SEQ_ONCE = 2'h3;
    localparam int REPEAT_COUNT = 8;
    localparam int RESULT_BITS = 10;
    localparam int MEM_DEPTH = 2;
    localparam int INT_LEAD_ONES = 6;
    localparam int EXT_LEAD_ONES = 4;
    localparam int EXT_START_DELAY = 2;
    // Stretch counter ceiling per scan set, in nanoseconds
    localparam int STRETCH_NS = 7600;
    localparam int STRETCH_CYCLES = (STRETCH_NS * (CLK_HZ / 1000000)) / 1000;

    typedef struct packed {
        logic [1:0] seq;
        logic pick;
        logic single;
    } conv_cfg_t;

    typedef struct packed {
        logic [RESULT_BITS-1:0] data;
    } result_t;

    typedef struct packed {
        logic pos_b;
        logic neg_a;
        logic neg_b;
        logic neg_gnd;
    } mux_sel_t;
endpackage

// File: verilog/result_skid.sv
// Purpose: two-entry valid/ready buffer on the result path
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact; no word lost on a stall
`timescale 1ns/100ps
module result_skid
    import adc_seq_pkg::*;
#(
    parameter int WIDTH = RESULT_BITS
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] slot [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = slot[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                slot[wr_ptr] <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// File: test/adc_seq_monitor.sv
// Purpose: protocol checks on the scan sequencer ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every sequencer instance
`timescale 1ns/100ps
module adc_seq_monitor
    import adc_seq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_oe,
    input wire logic conv_start,
    input wire mux_sel_t conv_mux,
    input wire logic conv_ext_clk,
    input wire logic conv_done,
    input wire logic [RESULT_BITS-1:0] conv_result,
    input wire logic busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic [3:0] starts;
    // Counts starts of one internal set; the first start may share the busy edge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            starts <= 4'h0;
        end else if (conv_start && !conv_ext_clk) begin
            starts <= (busy ? starts : 4'h0) + 4'h1;
        end else if (!busy) begin
            starts <= 4'h0;
        end
    end
    rst_vals_a: assert property (disable iff (1'b0)
        !nrst |=> !busy && !scl_oe && !sda_oe && !conv_ext_clk)
        else $error("outputs not idle after reset");
    mux_dflt_a: assert property (disable iff (1'b0)
        !nrst |=> conv_mux == mux_sel_t'(4'h1))
        else $error("input select not at default after reset");
    single_gnd_a: assert property (conv_mux.neg_gnd |-> !conv_mux.neg_a && !conv_mux.neg_b)
        else $error("single-ended with an input as negative");
    diff_pair_a: assert property (!conv_mux.neg_gnd |->
        conv_mux.neg_a == conv_mux.pos_b && conv_mux.neg_b != conv_mux.pos_b)
        else $error("differential pair polarity wrong");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    stretch_conv_a: assert property (conv_start && !conv_ext_clk |-> ##[0:1] scl_oe)
        else $error("internal conversion without clock stretch");
    stretch_low_a: assert property ($rose(scl_oe) |-> !scl_in)
        else $error("stretch began while bus clock high");
    sda_quiet_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved while bus clock high");
    scan_max_a: assert property (starts <= 4'h8)
        else $error("more than eight conversions in one set");
    clk_src_a: assert property (busy |-> $stable(conv_ext_clk))
        else $error("clock source changed during a set");
    busy_start_a: assert property (conv_start |-> ##[0:1] busy)
        else $error("conversion outside a read access");
    ext_start_c: cover property (conv_start && conv_ext_clk);
    stretch_end_c: cover property ($fell(scl_oe));
    eight_c: cover property (starts == 4'h8);
endmodule
bind adc_scan_readout_sequencer adc_seq_monitor u_mon (
    .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl_in), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_oe(sda_oe), .conv_start(conv_start), .conv_mux(conv_mux),
    .conv_ext_clk(conv_ext_clk), .conv_done(conv_done), .conv_result(conv_result),
    .busy(busy)
);

// File: test/bus_master_model.sv
// Purpose: two-wire bus master on the sequencer pins
// Assumes: pull-ups on both lines, 400 ns bus clock
// Notes: waits out clock stretch, bounded so a hang ends
`timescale 1ns/100ps
module bus_master_model (
    input wire logic clk_sys,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic scl_rel,
    output logic sda_rel
);
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Data moves one cycle after the fall, never with it
    task automatic bit_cyc(input logic b, output logic s);
        int k;
        tick(1);
        sda_rel <= b;
        tick(3);
        scl_rel <= 1'b1;
        k = 0;
        tick(1);
        while (!scl_pin && k < 4000) begin
            tick(1);
            k++;
        end
        tick(3);
        s = sda_pin;
        scl_rel <= 1'b0;
    endtask
    task automatic start;
        sda_rel <= 1'b0;
        tick(4);
        scl_rel <= 1'b0;
    endtask
    task automatic stop;
        tick(1);
        sda_rel <= 1'b0;
        tick(3);
        scl_rel <= 1'b1;
        tick(4);
        sda_rel <= 1'b1;
        tick(4);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], s);
        end
        bit_cyc(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, d[i]);
        end
        bit_cyc(!ack, s);
    endtask
endmodule

// File: test/tb_adc_scan_readout_sequencer.sv
// Purpose: self-checking bench for the scan readout sequencer
// Assumes: master model on the pins, behavioural converter core
// Notes: seed fixed at 72 so every run repeats
`timescale 1ns/100ps
module tb_adc_scan_readout_sequencer;
    import adc_seq_pkg::*;
    logic clk_sys, nrst, conv_done, scl_rel, sda_rel;
    logic conv_start, conv_ext_clk, busy, scl_oe, sda_oe;
    logic [RESULT_BITS-1:0] conv_result;
    logic [RESULT_BITS-1:0] res_q[$];
    logic [7:0] pos_hist, cfg;
    logic [1:0] seq;
    mux_sel_t conv_mux;
    wire logic scl_pin = scl_rel & ~scl_oe;
    wire logic sda_pin = sda_rel & ~sda_oe;
    int err_total, n_tests, seed, n_start, lat;
    int n_exp[4] = '{2, REPEAT_COUNT, 1, 1};
    adc_scan_readout_sequencer dut (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl_pin),
        .scl_oe(scl_oe), .sda_in(sda_pin), .sda_oe(sda_oe), .conv_start(conv_start),
        .conv_mux(conv_mux), .conv_ext_clk(conv_ext_clk), .conv_done(conv_done),
        .conv_result(conv_result), .busy(busy));
    bus_master_model mst (.clk_sys(clk_sys), .scl_pin(scl_pin), .sda_pin(sda_pin),
        .scl_rel(scl_rel), .sda_rel(sda_rel));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Converter core: random latency and value per start
    always @(posedge clk_sys) begin
        if (conv_done) res_q.push_back(conv_result);
        conv_done <= 1'b0;
        if (lat > 0) begin
            lat <= lat - 1;
            conv_done <= (lat == 1);
        end
        if (conv_start) begin
            conv_result <= RESULT_BITS'($random(seed));
            lat <= 3 + ($random(seed) & 7);
            n_start <= n_start + 1;
            pos_hist <= {pos_hist[6:0], conv_mux.pos_b};
        end
    end
    function automatic mux_sel_t mux_exp(input logic pick, input logic single);
        return single ? {pick, 3'h1} : {pick, pick, ~pick, 1'b0};
    endfunction
    function automatic logic [15:0] word_exp(input logic [9:0] r, input logic ext);
        return ext ? {4'hF, r, 2'h0} : {6'h3F, r};
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] b, input logic exp_ack);
        logic ack;
        mst.start();
        mst.wbyte({a, 1'b0}, ack);
        chk("addr ack", 16'(ack), 16'(exp_ack));
        if (ack) mst.wbyte(b, ack);
        mst.stop();
    endtask
    // Words past the stored depth must wrap to the first
    task automatic rd(input int n, input int depth, input logic ext, input logic full);
        logic ack;
        logic [7:0] hi, lo;
        logic [15:0] exp;
        res_q.delete();
        n_start = 0;
        mst.start();
        mst.wbyte({DEV_ADDR, 1'b1}, ack);
        chk("read ack", 16'(ack), 16'h1);
        for (int k = 0; k < n; k++) begin
            mst.rbyte(1'b1, hi);
            mst.rbyte(k < n - 1, lo);
            exp = word_exp(res_q[k % depth], ext);
            if (!full) exp[9:0] = {hi[1:0], lo};
            chk("word", {hi, lo}, exp);
        end
        chk("sda free", 16'(sda_oe), 16'h0);
        mst.stop();
    endtask
    initial begin
        seed = 72;
        nrst = 1'b0;
        conv_done = 1'b0;
        conv_result = '0;
        lat = 0;
        err_total = 0;
        n_tests = 0;
        pos_hist = '0;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("mux reset", 16'(conv_mux), 16'(mux_exp(1'b0, 1'b1)));
        chk("clk source", 16'(conv_ext_clk), 16'h0);
        rd(2, 1, 1'b0, 1'b1);
        chk("reset scan", 16'(n_start), 16'h1);
        wr(DEV_ADDR ^ 7'h01, 8'h00, 1'b0);
        for (int i = 0; i < 4; i++) begin
            cfg = {1'b0, SEQ_ONCE, 3'($random(seed)), i[1], i[0]};
            wr(DEV_ADDR, cfg, 1'b1);
            chk("mux", 16'(conv_mux), 16'(mux_exp(i[1], i[0])));
        end
        for (int i = 0; i < 4; i++) begin
            seq = 2'(i);
            wr(DEV_ADDR, {1'b0, seq, 3'h0, 1'b1, 1'b1}, 1'b1);
            rd(3, (seq == SEQ_UP) ? 2 : 1, 1'b0, seq != SEQ_EIGHT);
            chk("scan count", 16'(n_start), 16'(n_exp[i]));
            if (seq == SEQ_UP) chk("scan order", 16'(pos_hist[1:0]), 16'h1);
        end
        wr(DEV_ADDR, 8'h62, 1'b1);
        wr(DEV_ADDR, 8'h83, 1'b1);
        chk("no restore", 16'(conv_mux), 16'(mux_exp(1'b1, 1'b0)));
        wr(DEV_ADDR, 8'h81, 1'b1);
        chk("restore", 16'(conv_mux), 16'(mux_exp(1'b0, 1'b1)));
        wr(DEV_ADDR, 8'h8A, 1'b1);
        chk("ext clock", 16'(conv_ext_clk), 16'h1);
        for (int i = 0; i < 2; i++) begin
            wr(DEV_ADDR, i ? 8'h61 : 8'h21, 1'b1);
            rd(3, 3, 1'b1, 1'b1);
        end
        // Mid-run reset must drop external clock mode and the scan setup
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("clk after reset", 16'(conv_ext_clk), 16'h0);
        chk("busy after reset", 16'(busy), 16'h0);
        chk("mux after reset", 16'(conv_mux), 16'(mux_exp(1'b0, 1'b1)));
        rd(1, 1, 1'b0, 1'b1);
        chk("scan after reset", 16'(n_start), 16'h1);
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end
endmodule
